// ==== pkg/fsp_pkg.sv ====
// Constants, register map and shared types of the fast serial port control block
package fsp_pkg;

   // Clock and bit-rate arithmetic
   localparam int unsigned CLK_MHZ = 50;          // Block clock in MHz
   localparam int unsigned REF_CLK_MHZ = 48;      // Reference for the bit-rate divisor in MHz
   localparam int unsigned OVERSAMPLE = 8;        // Sub-ticks per bit time
   localparam logic [18:0] ACC_STEP = 19'(REF_CLK_MHZ * OVERSAMPLE); // Phase step per clock
   localparam logic [18:0] ACC_CLK = 19'(CLK_MHZ); // Phase weight per divisor count
   localparam logic [2:0] SUB_LAST = 3'h7;        // Last sub-tick of a bit
   localparam logic [2:0] SUB_HALF = 3'h3;        // Sub-tick at the middle of the start bit
   localparam logic [2:0] BIT_LAST = 3'h7;        // Last data bit index

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONTROL = 16'hc070;
   localparam logic [15:0] IDX_BAUD = 16'hc072;
   localparam logic [15:0] IDX_TX_GAP = 16'hc074;
   localparam logic [15:0] IDX_DATA = 16'hc076;
   localparam logic [15:0] IDX_RX_ADDR = 16'hc078;
   localparam logic [15:0] IDX_RX_LEN = 16'hc07a;
   localparam logic [15:0] IDX_TX_ADDR = 16'hc07c;
   localparam logic [15:0] IDX_TX_LEN = 16'hc07e;

   // Reset values
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [12:0] BAUD_RESET = 13'h0017;
   localparam logic [7:0] GAP_RESET = 8'h09;
   localparam logic [15:0] BLOCK_REG_RESET = 16'h0000;

   // Control register bit positions
   localparam int unsigned CB_ENABLE = 15;
   localparam int unsigned CB_RTS_POL = 14;
   localparam int unsigned CB_CTS_POL = 13;
   localparam int unsigned CB_XOFF = 12;
   localparam int unsigned CB_XOFF_EN = 11;
   localparam int unsigned CB_CTS_EN = 10;
   localparam int unsigned CB_RX_IE = 9;
   localparam int unsigned CB_DONE_IE = 8;
   localparam int unsigned CB_TX_DONE = 7;
   localparam int unsigned CB_RX_DONE = 6;
   localparam int unsigned CB_ONE_STOP = 5;
   localparam int unsigned CB_TX_READY = 4;
   localparam int unsigned CB_PKT_MODE = 3;
   localparam int unsigned CB_OVERFLOW = 2;
   localparam int unsigned CB_RX_FULL = 1;
   localparam int unsigned CB_RX_NONEMPTY = 0;
   localparam logic [15:0] CONTROL_RW_MASK = 16'hef28; // Plain read/write control bits

   // Flow control characters, FIFO depth and gap offset
   localparam logic [7:0] CHAR_XON = 8'h11;
   localparam logic [7:0] CHAR_XOFF = 8'h13;
   localparam logic [3:0] RX_DEPTH = 4'h8;
   localparam logic [7:0] GAP_OFFSET = 8'h07;

   // AHB-Lite request lines seen by the slave
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } fsp_ahb_req_type;

   // Serial line sequencer states, Gray along the frame
   typedef enum logic [1:0] {
      FSP_IDLE = 2'b00,
      FSP_START = 2'b01,
      FSP_DATA = 2'b11,
      FSP_STOP = 2'b10
   } fsp_line_state_type;

endpackage

// ==== verilog/fsp_rx_mem.sv ====
// Eight-byte receive buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module fsp_rx_mem (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [2:0] wr_addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [2:0] rd_addr_in,
   output logic [7:0] rd_data_out
);
   logic [7:0] mem_q [8]; // Byte storage
   logic [7:0] rd_data_q; // Read data register

   // Write port and registered read port
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_q <= mem_q[rd_addr_in];
   end

   assign rd_data_out = rd_data_q;
endmodule // fsp_rx_mem
`default_nettype wire

// ==== verilog/fsp_serial_port.sv ====
// Fast serial port: AHB-Lite registers, transmitter, receiver and receive FIFO
// Functional notes
// (R1) Port runs only while enable bit set
// (R2) Bit 14 selects request-to-send output polarity
// (R3) Bit 13 selects clear-to-send input polarity
// (R4) Status flag sets on XOFF, clears on XON
// (R5) Bit 11 turns XON/XOFF flow control on
// (R6) Bit 10 turns RTS/CTS handshaking on
// (R7) Bit 9 gates receive interrupts
// (R8) Bit 8 gates done interrupts
// (R9) Transmit-done flag set by hardware, write-one clears
// (R10) Receive-done flag set by hardware, write-one clears
// (R11) Bit 5 picks one or two stop bits
// (R12) Transmit ready shows holding register is free; the code also holds it low while the enable bit is clear
// (R13) Bit 3 picks receive interrupt source
// (R14) Overflow flag sticky until write-one clear
// (R15) Packet-ready reads one when FIFO full
// (R16) Receive ready reads one when FIFO nonempty
// (R17) Divisor resets to 0x0017, control to zero
// (R18) Bit rate is 48 MHz over divisor+1; divisors up to 6 give 6.25 MHz
// (R19) Data write sends byte, read pops byte
// (R20) Block mode gap is value minus seven bits
// (R21) Receive line follows enable and selected condition
// (R22) Done line follows enable and either flag
`timescale 1ns/1ps
`default_nettype none
module fsp_serial_port (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire fsp_pkg::fsp_ahb_req_type ahb_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic rxd_in,
   input wire logic cts_in,
   input wire logic tx_block_mode_in,
   input wire logic tx_block_done_in,
   input wire logic rx_block_done_in,
   output logic txd_out,
   output logic rts_out,
   output logic receive_interrupt_line_out,
   output logic done_intr_out
);
   import fsp_pkg::*;

   // Pin synchronisers: index 0 is the receive line, 1 the clear-to-send line
   logic [1:0] pin_raw; // Raw pin levels
   logic [1:0] pin_flt; // Filtered levels
   assign pin_raw = {cts_in, rxd_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         logic [2:0] sync_q; // Three-stage chain
         logic [2:0] sync_d;
         logic flt_q; // Accepted level
         logic flt_d;
         // Level is accepted once the second and third stages agree
         always_comb begin
            sync_d = {sync_q[1:0], pin_raw[gi]};
            flt_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : flt_q;
         end
         // Idle line level is high
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               sync_q <= 3'h7;
               flt_q <= 1'b1;
            end else begin
               sync_q <= sync_d;
               flt_q <= flt_d;
            end
         end
         assign pin_flt[gi] = flt_q;
      end
   endgenerate

   logic rxd_flt;
   logic cts_flt;
   assign rxd_flt = pin_flt[0];
   assign cts_flt = pin_flt[1];

   // Register state
   logic [15:0] ctrl_q, ctrl_d; // Plain control bits
   logic xoff_q, xoff_d; // XOFF seen
   logic txdone_q, txdone_d; // Block transmit done
   logic rxdone_q, rxdone_d; // Block receive done
   logic ovf_q, ovf_d; // Receive overflow
   logic [12:0] baud_q, baud_d; // Bit-rate divisor
   logic [7:0] gap_q, gap_d; // Block-mode gap
   logic [15:0] blk_q [4]; // Block address and length storage
   logic [15:0] blk_d [4];
   logic wr_pend_q, wr_pend_d; // Write data phase pending
   logic [17:0] wr_addr_q, wr_addr_d; // Address of that write
   logic [31:0] rdata_q, rdata_d; // Read data
   logic [3:0] rx_cnt_q, rx_cnt_d; // FIFO fill level
   logic [2:0] wr_ptr_q, wr_ptr_d;
   logic [2:0] rd_ptr_q, rd_ptr_d;
   logic [7:0] hold_q, hold_d; // Transmit holding byte
   logic hold_vld_q, hold_vld_d;

   // Decoded control bits
   logic en, rts_pol, cts_pol, xoff_en, cts_en, rx_ie, done_ie, one_stop, pkt_mode;
   assign en = ctrl_q[CB_ENABLE];
   assign rts_pol = ctrl_q[CB_RTS_POL];
   assign cts_pol = ctrl_q[CB_CTS_POL];
   assign xoff_en = ctrl_q[CB_XOFF_EN];
   assign cts_en = ctrl_q[CB_CTS_EN];
   assign rx_ie = ctrl_q[CB_RX_IE];
   assign done_ie = ctrl_q[CB_DONE_IE];
   assign one_stop = ctrl_q[CB_ONE_STOP];
   assign pkt_mode = ctrl_q[CB_PKT_MODE];

   // Status terms
   logic rx_full, rx_nonempty, tx_ready, cts_true, rts_true;
   assign rx_full = (rx_cnt_q == RX_DEPTH); // [R15]
   assign rx_nonempty = (rx_cnt_q != 4'h0); // [R16]
   assign tx_ready = en && !hold_vld_q; // [R12]
   assign cts_true = cts_flt ^ cts_pol; // [R3]
   assign rts_true = en && !(cts_en && rx_full); // [R6]

   // Bit-rate phase accumulator: average tick rate is 8 x 48 MHz / (divisor + 1) for divisors of 7 and up, one tick per clock below that
   logic [18:0] acc_q, acc_d;
   logic os_tick_q, os_tick_d;
   logic [18:0] acc_sum, acc_thr;
   always_comb begin
      acc_thr = ACC_CLK * (19'(baud_q) + 19'h1); // [R18]
      acc_sum = acc_q + ACC_STEP;
      acc_d = acc_sum;
      os_tick_d = 1'b0;
      if (!en) begin
         acc_d = 19'h0;
      end else if (acc_sum >= acc_thr) begin
         os_tick_d = 1'b1;
         // Out-of-range divisors must not let the phase run away
         acc_d = ((acc_sum - acc_thr) >= acc_thr) ? 19'h0 : acc_sum - acc_thr;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         acc_q <= 19'h0;
         os_tick_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         os_tick_q <= os_tick_d;
      end
   end

   // Transmitter
   fsp_line_state_type tx_st_q, tx_st_d;
   logic [2:0] tx_sub_q, tx_sub_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic [7:0] tx_stop_q, tx_stop_d; // Stop bits still to send
   logic txd_q, txd_d;
   logic tx_go, tx_bit_end, tx_take;
   logic [7:0] stop_len;
   assign tx_go = hold_vld_q && (!cts_en || cts_true) && !(xoff_en && xoff_q); // [R5] [R6]
   assign tx_bit_end = os_tick_q && (tx_sub_q == SUB_LAST);
   assign tx_take = en && (tx_st_q == FSP_IDLE) && tx_go;
   always_comb begin
      // Block mode uses the gap count, byte mode the stop-bit select
      if (tx_block_mode_in) begin
         stop_len = (gap_q > GAP_OFFSET) ? gap_q - GAP_OFFSET : 8'h01; // [R20]
      end else begin
         stop_len = one_stop ? 8'h01 : 8'h02; // [R11]
      end
      tx_st_d = tx_st_q;
      tx_sub_d = os_tick_q ? tx_sub_q + 3'h1 : tx_sub_q;
      tx_bit_d = tx_bit_q;
      tx_sh_d = tx_sh_q;
      tx_stop_d = tx_stop_q;
      txd_d = txd_q;
      if (!en) begin
         tx_st_d = FSP_IDLE; // [R1]
         tx_sub_d = 3'h0;
         txd_d = 1'b1;
      end else begin
         unique case (tx_st_q)
            FSP_IDLE: begin
               tx_sub_d = 3'h0;
               if (tx_go) begin
                  tx_st_d = FSP_START;
                  tx_sh_d = hold_q;
                  txd_d = 1'b0;
               end
            end
            FSP_START: begin
               if (tx_bit_end) begin
                  tx_st_d = FSP_DATA;
                  tx_bit_d = 3'h0;
                  txd_d = tx_sh_q[0];
               end
            end
            FSP_DATA: begin
               if (tx_bit_end) begin
                  if (tx_bit_q == BIT_LAST) begin
                     tx_st_d = FSP_STOP;
                     tx_stop_d = stop_len;
                     txd_d = 1'b1;
                  end else begin
                     tx_bit_d = tx_bit_q + 3'h1;
                     tx_sh_d = {1'b0, tx_sh_q[7:1]};
                     txd_d = tx_sh_q[1];
                  end
               end
            end
            FSP_STOP: begin
               if (tx_bit_end) begin
                  if (tx_stop_q <= 8'h01) begin
                     tx_st_d = FSP_IDLE;
                  end else begin
                     tx_stop_d = tx_stop_q - 8'h01;
                  end
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_st_q <= FSP_IDLE;
         tx_sub_q <= 3'h0;
         tx_bit_q <= 3'h0;
         tx_sh_q <= 8'h00;
         tx_stop_q <= 8'h00;
         txd_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_sub_q <= tx_sub_d;
         tx_bit_q <= tx_bit_d;
         tx_sh_q <= tx_sh_d;
         tx_stop_q <= tx_stop_d;
         txd_q <= txd_d;
      end
   end

   // Receiver: start bit checked at mid-bit, one stop bit checked, extra stop bits idle
   fsp_line_state_type rx_st_q, rx_st_d;
   logic [2:0] rx_sub_q, rx_sub_d;
   logic [2:0] rx_bit_q, rx_bit_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic rx_got; // Complete byte with valid stop bit
   assign rx_got = en && (rx_st_q == FSP_STOP) && os_tick_q && (rx_sub_q == SUB_LAST) && rxd_flt;
   always_comb begin
      rx_st_d = rx_st_q;
      rx_sub_d = os_tick_q ? rx_sub_q + 3'h1 : rx_sub_q;
      rx_bit_d = rx_bit_q;
      rx_sh_d = rx_sh_q;
      if (!en) begin
         rx_st_d = FSP_IDLE; // [R1]
         rx_sub_d = 3'h0;
      end else begin
         unique case (rx_st_q)
            FSP_IDLE: begin
               rx_sub_d = 3'h0;
               if (!rxd_flt) begin
                  rx_st_d = FSP_START;
               end
            end
            FSP_START: begin
               if (os_tick_q && rx_sub_q == SUB_HALF) begin
                  rx_sub_d = 3'h0;
                  rx_bit_d = 3'h0;
                  rx_st_d = rxd_flt ? FSP_IDLE : FSP_DATA;
               end
            end
            FSP_DATA: begin
               if (os_tick_q && rx_sub_q == SUB_LAST) begin
                  rx_sh_d = {rxd_flt, rx_sh_q[7:1]};
                  rx_bit_d = rx_bit_q + 3'h1;
                  if (rx_bit_q == BIT_LAST) begin
                     rx_st_d = FSP_STOP;
                  end
               end
            end
            FSP_STOP: begin
               // Framing errors drop the byte
               if (os_tick_q && rx_sub_q == SUB_LAST) begin
                  rx_st_d = FSP_IDLE; // [R11]
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_st_q <= FSP_IDLE;
         rx_sub_q <= 3'h0;
         rx_bit_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end else begin
         rx_st_q <= rx_st_d;
         rx_sub_q <= rx_sub_d;
         rx_bit_q <= rx_bit_d;
         rx_sh_q <= rx_sh_d;
      end
   end

   // Receive FIFO storage
   logic [7:0] fifo_rd_data;
   logic push, pop, is_xon, is_xoff;
   fsp_rx_mem u_rx_mem (
      .clk_in(clk_in),
      .wr_en_in(push),
      .wr_addr_in(wr_ptr_q),
      .wr_data_in(rx_sh_q),
      .rd_addr_in(rd_ptr_q),
      .rd_data_out(fifo_rd_data)
   );

   // Bus decode
   logic accept, wr_ctrl, wr_data;
   logic [15:0] wd;
   logic [15:0] ctrl_rd;
   assign accept = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
   assign wd = hwdata_in[15:0];
   assign wr_ctrl = wr_pend_q && (wr_addr_q == {IDX_CONTROL, 2'b00});
   assign wr_data = wr_pend_q && (wr_addr_q == {IDX_DATA, 2'b00});
   assign is_xon = xoff_en && (rx_sh_q == CHAR_XON);
   assign is_xoff = xoff_en && (rx_sh_q == CHAR_XOFF);
   assign push = rx_got && !is_xon && !is_xoff && !rx_full;
   assign pop = accept && !ahb_in.hwrite && rx_nonempty
                && (ahb_in.haddr[17:0] == {IDX_DATA, 2'b00}); // [R19]

   // Control read view with live status bits
   always_comb begin
      ctrl_rd = ctrl_q;
      ctrl_rd[CB_XOFF] = xoff_q; // [R4]
      ctrl_rd[CB_TX_DONE] = txdone_q;
      ctrl_rd[CB_RX_DONE] = rxdone_q;
      ctrl_rd[CB_TX_READY] = tx_ready; // [R12]
      ctrl_rd[CB_OVERFLOW] = ovf_q;
      ctrl_rd[CB_RX_FULL] = rx_full; // [R15]
      ctrl_rd[CB_RX_NONEMPTY] = rx_nonempty; // [R16]
   end

   // Register file, flags and FIFO pointers
   always_comb begin
      ctrl_d = ctrl_q;
      baud_d = baud_q;
      gap_d = gap_q;
      blk_d = blk_q;
      hold_d = hold_q;
      hold_vld_d = hold_vld_q && !tx_take;
      wr_pend_d = accept && ahb_in.hwrite;
      wr_addr_d = ahb_in.haddr[17:0];
      rdata_d = rdata_q;
      xoff_d = xoff_q;
      wr_ptr_d = wr_ptr_q + (push ? 3'h1 : 3'h0);
      rd_ptr_d = rd_ptr_q + (pop ? 3'h1 : 3'h0);
      rx_cnt_d = rx_cnt_q + (push ? 4'h1 : 4'h0) - (pop ? 4'h1 : 4'h0);
      // Write-one clears; a same-cycle set wins
      txdone_d = (txdone_q && !(wr_ctrl && wd[CB_TX_DONE])) || tx_block_done_in; // [R9]
      rxdone_d = (rxdone_q && !(wr_ctrl && wd[CB_RX_DONE])) || rx_block_done_in; // [R10]
      ovf_d = (ovf_q && !(wr_ctrl && wd[CB_OVERFLOW])) || (rx_got && rx_full); // [R14]
      if (is_xoff && rx_got) begin
         xoff_d = 1'b1; // [R4]
      end else if ((is_xon && rx_got) || !xoff_en) begin
         xoff_d = 1'b0; // [R4] [R5]
      end
      // Read data captured at the address phase
      if (accept && !ahb_in.hwrite) begin
         unique case (ahb_in.haddr[17:0])
            {IDX_CONTROL, 2'b00}: rdata_d = {16'h0000, ctrl_rd};
            {IDX_BAUD, 2'b00}: rdata_d = {19'h00000, baud_q};
            {IDX_TX_GAP, 2'b00}: rdata_d = {24'h000000, gap_q};
            {IDX_DATA, 2'b00}: rdata_d = {24'h000000, fifo_rd_data}; // [R19]
            {IDX_RX_ADDR, 2'b00}: rdata_d = {16'h0000, blk_q[0]};
            {IDX_RX_LEN, 2'b00}: rdata_d = {16'h0000, blk_q[1]};
            {IDX_TX_ADDR, 2'b00}: rdata_d = {16'h0000, blk_q[2]};
            {IDX_TX_LEN, 2'b00}: rdata_d = {16'h0000, blk_q[3]};
            default: rdata_d = 32'h00000000;
         endcase
      end
      // Writes land at the end of the data phase
      if (wr_ctrl) begin
         ctrl_d = wd & CONTROL_RW_MASK;
      end
      if (wr_pend_q) begin
         unique case (wr_addr_q)
            {IDX_BAUD, 2'b00}: baud_d = wd[12:0];
            {IDX_TX_GAP, 2'b00}: gap_d = wd[7:0];
            {IDX_RX_ADDR, 2'b00}: blk_d[0] = wd;
            {IDX_RX_LEN, 2'b00}: blk_d[1] = wd;
            {IDX_TX_ADDR, 2'b00}: blk_d[2] = wd;
            {IDX_TX_LEN, 2'b00}: blk_d[3] = wd;
            default: ;
         endcase
      end
      if (wr_data && tx_ready) begin
         hold_d = wd[7:0]; // [R19]
         hold_vld_d = 1'b1;
      end
      // Disabled port drops the holding byte and empties the FIFO
      if (!en) begin
         hold_vld_d = 1'b0; // [R1]
         wr_ptr_d = 3'h0;
         rd_ptr_d = 3'h0;
         rx_cnt_d = 4'h0;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= CONTROL_RESET; // [R17]
         baud_q <= BAUD_RESET; // [R17]
         gap_q <= GAP_RESET; // [R20]
         blk_q <= '{default: BLOCK_REG_RESET};
         xoff_q <= 1'b0;
         txdone_q <= 1'b0;
         rxdone_q <= 1'b0;
         ovf_q <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 18'h00000;
         rdata_q <= 32'h00000000;
         rx_cnt_q <= 4'h0;
         wr_ptr_q <= 3'h0;
         rd_ptr_q <= 3'h0;
         hold_q <= 8'h00;
         hold_vld_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         baud_q <= baud_d;
         gap_q <= gap_d;
         blk_q <= blk_d;
         xoff_q <= xoff_d;
         txdone_q <= txdone_d;
         rxdone_q <= rxdone_d;
         ovf_q <= ovf_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         rx_cnt_q <= rx_cnt_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         hold_q <= hold_d;
         hold_vld_q <= hold_vld_d;
      end
   end

   // Outputs
   assign hrdata_out = rdata_q;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign txd_out = txd_q;
   assign rts_out = rts_true ^ rts_pol; // [R2]
   assign receive_interrupt_line_out = rx_ie && (pkt_mode ? rx_full : rx_nonempty); // [R7] [R13] [R21]
   assign done_intr_out = done_ie && (txdone_q || rxdone_q); // [R8] [R22]

   // Checks
   AST_DISABLED_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
      !en |=> txd_out && tx_st_q == FSP_IDLE) else $error("Disabled port not idle");
   AST_RTS_FULL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
      (en && cts_en && rx_full) |-> (rts_out == rts_pol)) else $error("RTS not withdrawn");
   AST_CTS_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
      (tx_st_q == FSP_IDLE && cts_en && (cts_flt ^ cts_pol) == 1'b0) |=> tx_st_q == FSP_IDLE)
      else $error("Sent without clear to send");
   AST_XOFF_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
      (rx_got && is_xoff) |=> xoff_q) else $error("XOFF not flagged");
   AST_XOFF_STALL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
      (tx_st_q == FSP_IDLE && xoff_en && xoff_q) |=> tx_st_q == FSP_IDLE)
      else $error("Sent while stopped by XOFF");
   AST_RX_IE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R7]
      !rx_ie |-> !receive_interrupt_line_out) else $error("Receive line while masked");
   AST_TXDONE_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R9]
      tx_block_done_in |=> txdone_q ##1 (txdone_q || $past(wr_ctrl)))
      else $error("Transmit done lost");
   AST_OVF_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
      (rx_got && rx_full && !pop) |=> ovf_q && rx_cnt_q == RX_DEPTH) else $error("Overflow lost");
   AST_TX_READY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
      (wr_data && tx_ready) |=> !tx_ready) else $error("Ready after load");
   AST_BAUD_RESET: assert property (@(posedge clk_in) // [R17]
      $rose(rst_n_in) |-> baud_q == BAUD_RESET && ctrl_q == CONTROL_RESET)
      else $error("Bad reset values");
endmodule // fsp_serial_port
`default_nettype wire

// ==== verification/fsp_peer.sv ====
// Remote serial peer that frames bytes onto the receive pin and captures sent bytes
`timescale 1ns/1ps
`default_nettype none
module fsp_peer (
   input wire logic txd_in,
   output logic rxd_out
);
   localparam time BIT_NS = 500; // Bit time at the reset divisor
   logic [7:0] got; // Last byte taken from the transmit line
   // Line idles high
   initial begin
      rxd_out = 1'b1;
   end
   // Start bit, eight data bits LSB first, then idle high
   task automatic send(input logic [7:0] b);
      rxd_out = 1'b0;
      #BIT_NS;
      for (int i = 0; i < 8; i++) begin
         rxd_out = b[i];
         #BIT_NS;
      end
      rxd_out = 1'b1;
      #(3 * BIT_NS);
   endtask
   // Wait for a start edge, then sample each data bit at its middle
   task automatic grab();
      @(negedge txd_in);
      #(BIT_NS * 3 / 2);
      for (int i = 0; i < 8; i++) begin
         got[i] = txd_in;
         #BIT_NS;
      end
   endtask
endmodule // fsp_peer
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the fast serial port control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fsp_pkg::*;
   logic clk_in, rst_n_in, rxd, cts, tx_bdone, rx_bdone, txd, rts, rx_irq, done_irq, hresp, hrdy;
   fsp_ahb_req_type ahb; // Address phase lines
   fsp_ahb_req_type ahb_bus; // Request as the slave sees it, hready fed back
   assign ahb_bus = {ahb[39:1], hrdy};
   logic [31:0] hwdata, hrdata; // Data phase buses
   int n_errors = 0;
   int check_count = 0;
   logic [15:0] r; // Last read value
   fsp_serial_port dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ahb_in(ahb_bus), .hwdata_in(hwdata),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .rxd_in(rxd), .cts_in(cts),
      .tx_block_mode_in(1'b0), .tx_block_done_in(tx_bdone), .rx_block_done_in(rx_bdone),
      .txd_out(txd), .rts_out(rts), .receive_interrupt_line_out(rx_irq), .done_intr_out(done_irq));
   fsp_peer peer (.txd_in(txd), .rxd_out(rxd));
   // 50 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One single AHB-Lite transfer, then one idle cycle
   task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd);
      @(posedge clk_in);
      ahb.htrans <= 2'b10;
      ahb.haddr <= {14'h0, idx, 2'b00};
      ahb.hwrite <= w;
      do @(posedge clk_in); while (hrdy !== 1'b1);
      ahb.htrans <= 2'b00;
      hwdata <= {16'h0, wd};
      do @(posedge clk_in); while (hrdy !== 1'b1);
      r = hrdata[15:0];
      chk("hresp", {15'h0, hresp}, 16'h0);
      @(posedge clk_in);
   endtask
   // Reset values of control, divisor and gap, and the divisor field width
   task automatic t_reset();
      bus(0, IDX_CONTROL, 0);
      chk("control", r, 16'h0000);
      bus(0, IDX_BAUD, 0);
      chk("baud", r, 16'h0017);
      bus(1, IDX_BAUD, 16'hffff);
      bus(0, IDX_BAUD, 0);
      chk("baud field", r, 16'h1fff);
      bus(1, IDX_BAUD, 16'h0017);
      bus(0, IDX_TX_GAP, 0);
      chk("gap", r, 16'h0009);
   endtask
   // Enable, ready flag and request-to-send polarity
   task automatic t_enable();
      bus(1, IDX_CONTROL, 16'h8000);
      bus(0, IDX_CONTROL, 0);
      chk("enabled", r, 16'h8010);
      chk("rts high", {15'h0, rts}, 16'h1);
      bus(1, IDX_CONTROL, 16'hc000);
      chk("rts low", {15'h0, rts}, 16'h0);
   endtask
   // Block done flags, done interrupt and write-one clear
   task automatic t_done();
      bus(1, IDX_CONTROL, 16'h8100);
      tx_bdone <= 1'b1;
      rx_bdone <= 1'b1;
      @(posedge clk_in);
      tx_bdone <= 1'b0;
      rx_bdone <= 1'b0;
      @(posedge clk_in);
      bus(0, IDX_CONTROL, 0);
      chk("flags", r, 16'h81d0);
      chk("done irq", {15'h0, done_irq}, 16'h1);
      bus(1, IDX_CONTROL, 16'h0080);
      bus(0, IDX_CONTROL, 0);
      chk("tx clr", r, 16'h0040);
      chk("done off", {15'h0, done_irq}, 16'h0);
   endtask
   // One byte each way
   task automatic t_xfer();
      bus(1, IDX_CONTROL, 16'h8060);
      fork
         peer.grab();
         bus(1, IDX_DATA, 16'h005a);
      join
      chk("txd", {8'h0, peer.got}, 16'h005a);
      peer.send(8'ha5);
      bus(0, IDX_CONTROL, 0);
      chk("rx ready", r, 16'h8031);
      bus(0, IDX_DATA, 0);
      chk("rx byte", r, 16'h00a5);
      bus(0, IDX_CONTROL, 0);
      chk("rx empty", r, 16'h8030);
   endtask
   // XOFF/XON flag and clear-to-send gating of the transmitter
   task automatic t_flow();
      bus(1, IDX_CONTROL, 16'h8c20);
      peer.send(CHAR_XOFF);
      bus(0, IDX_CONTROL, 0);
      chk("xoff", r, 16'h9c30);
      peer.send(CHAR_XON);
      bus(0, IDX_CONTROL, 0);
      chk("xon", r, 16'h8c30);
      bus(1, IDX_DATA, 16'h0033);
      repeat (100) @(posedge clk_in);
      chk("cts hold", {15'h0, txd}, 16'h1);
      fork
         peer.grab();
         cts <= 1'b1;
      join
      chk("cts go", {8'h0, peer.got}, 16'h0033);
   endtask
   // Fill past eight bytes, check full, overflow and the receive interrupt
   task automatic t_full();
      bus(1, IDX_CONTROL, 16'h8008);
      for (int i = 0; i < 9; i++) begin
         peer.send(8'(i));
      end
      chk("irq gated", {15'h0, rx_irq}, 16'h0);
      bus(1, IDX_CONTROL, 16'h8608);
      chk("pkt irq", {15'h0, rx_irq}, 16'h1);
      chk("rts full", {15'h0, rts}, 16'h0);
      bus(0, IDX_CONTROL, 0);
      chk("full", r, 16'h861f);
      bus(1, IDX_CONTROL, 16'h8204);
      bus(0, IDX_CONTROL, 0);
      chk("ovf clr", r, 16'h8213);
      chk("rdy irq", {15'h0, rx_irq}, 16'h1);
   endtask
   // Report and end the run
   task automatic results();
      $display("Errors %0d, checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #500us;
      n_errors++;
      results();
   end
   // Main sequence
   initial begin
      ahb = '{hsel: 1'b1, haddr: 32'h0, htrans: 2'b00, hwrite: 1'b0, hsize: 3'h2, hready: 1'b1};
      hwdata = 32'h0;
      cts = 1'b0;
      tx_bdone = 1'b0;
      rx_bdone = 1'b0;
      rst_n_in = 1'b0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_enable();
      t_done();
      t_xfer();
      t_flow();
      t_full();
      results();
   end
endmodule // tb
`default_nettype wire
